/* File: hdl/pit_timer.sv */
// Purpose: 16-bit down-counting interval timer with control register
// Assumes: register port strobes are synchronous to clock, one cycle each
// Notes: the bus Enable clock is the block clock itself
`timescale 1ns/1ps
`default_nettype none
`include "pit_defs.svh"

module pit_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic bus_sel,
    input wire logic bus_read,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic irq_n,
    input wire logic gate_input,
    input wire logic external_clock_input,
    output logic timer_output
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0] timer_control;
        logic [7:0] msb_buf;
        logic [15:0] latch;
        logic [15:0] cnt;
        logic [2:0] pre;
        logic g1;
        logic g2;
        logic g3;
        logic c1;
        logic c2;
        logic c3;
        logic flag;
        logic armed;
        logic timeout_tracking_flag;
        logic ce;
        logic out;
        logic pin;
        logic [7:0] rdata;
    } pit_state_t;

    localparam pit_state_t RST_S = '{
        timer_control: `PIT_CTRL_RST,
        latch: `PIT_LATCH_RST,
        cnt: `PIT_LATCH_RST,
        default: '0
    };

    function automatic pit_pkg::pit_mode_t mode_of(input logic [7:0] c);
        if (c[`PIT_MODE3]) begin
            mode_of = c[`PIT_MODE4] ? pit_pkg::PIT_PWID : pit_pkg::PIT_FREQ;
        end else if (!c[`PIT_MODE5]) begin
            mode_of = pit_pkg::PIT_CONT;
        end else if (c[`PIT_MODE4]) begin
            mode_of = pit_pkg::PIT_SS_NORM;
        end else begin
            mode_of = pit_pkg::PIT_SS_CASC;
        end
    endfunction

    pit_state_t s_q;
    pit_state_t s_d;
    pit_pkg::pit_mode_t mode_q;
    logic soft_rst;
    logic gfall;
    logic grise;
    logic src_tick;
    logic clk_en;
    logic cnt_en;
    logic counter_timeout;
    logic counter_initialization;
    logic latch_wr;
    logic status_then_counter_read;
    logic flag_set;
    logic flag_clr;
    logic [15:0] latch_new;

    assign mode_q = mode_of(s_q.timer_control);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        soft_rst = s_q.timer_control[`PIT_SOFT_RST];
        s_d.g1 = gate_input;
        s_d.g2 = s_q.g1;
        s_d.g3 = s_q.g2;
        s_d.c1 = external_clock_input;
        s_d.c2 = s_q.c1;
        s_d.c3 = s_q.c2;
        gfall = s_q.g3 & ~s_q.g2;
        grise = ~s_q.g3 & s_q.g2;

        src_tick = s_q.timer_control[`PIT_CLK_SEL] | (s_q.c2 & ~s_q.c3);
        if (src_tick && !soft_rst) begin
            s_d.pre = s_q.pre + 3'h1;
        end
        if (s_q.timer_control[`PIT_PRE_EN]) begin
            clk_en = src_tick & (s_q.pre == `PIT_PRE_LAST);
        end else begin
            clk_en = src_tick;
        end
        // clocks held off during soft reset
        clk_en = clk_en & ~soft_rst;

        // register writes; control and latch stay writable in soft reset
        latch_wr = bus_sel & ~bus_read & (bus_addr == `PIT_A_CNT_LO);
        latch_new = s_q.latch;
        if (bus_sel && !bus_read) begin
            case (bus_addr)
                `PIT_A_CTRL: s_d.timer_control = bus_wdata;
                `PIT_A_CNT_HI: s_d.msb_buf = bus_wdata;
                default: ;
            endcase
        end
        if (latch_wr) begin
            latch_new = {s_q.msb_buf, bus_wdata};
        end
        s_d.latch = latch_new;

        // per-mode enable, init and flag set
        flag_set = 1'b0;
        counter_initialization = soft_rst;
        case (mode_q)
            pit_pkg::PIT_CONT: begin
                cnt_en = ~s_q.g2;
                counter_initialization = counter_initialization | gfall |
                    (latch_wr & ~s_q.timer_control[`PIT_MODE4]);
            end
            pit_pkg::PIT_SS_NORM, pit_pkg::PIT_SS_CASC: begin
                cnt_en = 1'b1;
                counter_initialization = counter_initialization | gfall |
                    (latch_wr & ~s_q.timer_control[`PIT_MODE4]);
            end
            pit_pkg::PIT_FREQ: begin
                cnt_en = s_q.ce;
                if (!s_q.timer_control[`PIT_MODE5]) begin
                    counter_initialization = counter_initialization |
                        (gfall & ~s_q.flag &
                         (~s_q.ce | s_q.timeout_tracking_flag));
                end else begin
                    counter_initialization = counter_initialization |
                        (gfall & ~s_q.flag);
                end
            end
            default: begin
                cnt_en = s_q.ce;
                counter_initialization = counter_initialization |
                    (gfall & ~s_q.flag);
            end
        endcase
        counter_timeout = clk_en & cnt_en & (s_q.cnt == `PIT_CNT_ZERO);

        if (s_q.timer_control[`PIT_MODE3]) begin
            case ({s_q.timer_control[`PIT_MODE4],
                   s_q.timer_control[`PIT_MODE5]})
                2'b00: flag_set = gfall & s_q.ce &
                    ~s_q.timeout_tracking_flag;
                2'b10: flag_set = grise & s_q.ce &
                    ~s_q.timeout_tracking_flag;
                default: flag_set = counter_timeout;
            endcase
            flag_set = flag_set & ~soft_rst;
        end else begin
            flag_set = counter_timeout;
        end

        if (counter_initialization) begin
            s_d.cnt = latch_new;
        end else if (clk_en && cnt_en) begin
            if (s_q.cnt == `PIT_CNT_ZERO) begin
                s_d.cnt = s_q.latch;
            end else begin
                s_d.cnt = s_q.cnt - 16'h0001;
            end
        end

        if (counter_initialization) begin
            s_d.timeout_tracking_flag = counter_timeout;
        end else if (counter_timeout) begin
            s_d.timeout_tracking_flag = 1'b1;
        end

        if (latch_wr || soft_rst || s_q.flag ||
            (mode_q == pit_pkg::PIT_PWID && s_q.g2)) begin
            s_d.ce = 1'b0;
        end else if (gfall) begin
            s_d.ce = 1'b1;
        end

        status_then_counter_read = bus_sel & bus_read & s_q.armed &
            (bus_addr == `PIT_A_CNT_HI);
        if (status_then_counter_read) begin
            s_d.armed = 1'b0;
        end else if (bus_sel && bus_read && bus_addr == `PIT_A_STAT) begin
            s_d.armed = s_q.flag;
        end
        // latch write also clears in interval modes
        flag_clr = soft_rst | counter_initialization |
            status_then_counter_read |
            (latch_wr & s_q.timer_control[`PIT_MODE3]);
        // a timeout landing on a clear is kept
        s_d.flag = flag_set | (s_q.flag & ~flag_clr);

        // output waveform; undefined in interval modes, held low there
        if (soft_rst || s_q.timer_control[`PIT_MODE3]) begin
            s_d.out = 1'b0;
        end else if (counter_initialization) begin
            s_d.out = (mode_q == pit_pkg::PIT_SS_NORM) ? 1'b1 :
                (mode_q == pit_pkg::PIT_SS_CASC) ? s_q.out : 1'b0;
        end else if (counter_timeout) begin
            case (mode_q)
                pit_pkg::PIT_CONT: s_d.out = ~s_q.out;
                pit_pkg::PIT_SS_NORM: s_d.out = 1'b0;
                default: s_d.out = s_q.timer_control[`PIT_OUT_CTL];
            endcase
        end
        if (mode_of(s_d.timer_control) == pit_pkg::PIT_SS_CASC) begin
            s_d.pin = s_d.out;
        end else begin
            s_d.pin = s_d.out & s_d.timer_control[`PIT_OUT_CTL];
        end

        // counter reads independent of output control
        if (bus_sel && bus_read) begin
            case (bus_addr)
                `PIT_A_CTRL: s_d.rdata = s_q.timer_control;
                `PIT_A_STAT: s_d.rdata = {s_q.flag &
                    s_q.timer_control[`PIT_IRQ_EN], 6'h00, s_q.flag};
                `PIT_A_CNT_HI: s_d.rdata = s_q.cnt[15:8];
                `PIT_A_CNT_LO: s_d.rdata = s_q.cnt[7:0];
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= RST_S;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign bus_rdata = s_q.rdata;
    assign irq_n = ~(s_q.flag & s_q.timer_control[`PIT_IRQ_EN]);
    assign timer_output = s_q.pin;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // a write that turns the prescaler off lets the next tick through
    AST_PRESCALE: assert property (
        clk_en && s_q.timer_control[`PIT_PRE_EN] &&
        $stable(s_q.timer_control) |=>
        (!clk_en || !s_q.timer_control[`PIT_PRE_EN]) [*7])
        else $error("prescaled counter clock came early");
    AST_IRQ_MASK: assert property (
        !s_q.timer_control[`PIT_IRQ_EN] |-> irq_n)
        else $error("masked flag reached irq");
    AST_OUT_FORCE: assert property (
        mode_q != pit_pkg::PIT_SS_CASC &&
        !s_q.timer_control[`PIT_OUT_CTL] |-> !timer_output)
        else $error("disabled output not low");
    AST_CONT_GATE: assert property (
        mode_q == pit_pkg::PIT_CONT && s_q.g2 && !counter_initialization
        |=> $stable(s_q.cnt))
        else $error("continuous mode counted with gate high");
    AST_SS_LOW: assert property (
        mode_q == pit_pkg::PIT_SS_NORM && counter_timeout &&
        !counter_initialization && $stable(s_q.timer_control)
        |=> !timer_output)
        else $error("single-shot output not low after timeout");
    AST_LATCH_WR: assert property (
        latch_wr |=> s_q.latch == {$past(s_q.msb_buf), $past(bus_wdata)})
        else $error("latch write did not load both bytes");
    AST_RELOAD: assert property (
        counter_timeout && !counter_initialization && !latch_wr
        |=> s_q.cnt == $past(s_q.latch))
        else $error("no reload after timeout");
    AST_INIT_CLR: assert property (
        counter_initialization && !flag_set |=> !s_q.flag)
        else $error("initialisation left the flag set");
    AST_SOFT_RST: assert property (
        soft_rst && !latch_wr |=> s_q.cnt == $past(s_q.latch) &&
        !s_q.flag && !s_q.out)
        else $error("soft reset did not preset");
    AST_TOF: assert property (
        counter_initialization |=>
        s_q.timeout_tracking_flag == $past(counter_timeout))
        else $error("tracking flag wrong after init");
    AST_PW_STOP: assert property (
        mode_q == pit_pkg::PIT_PWID && grise |=> !s_q.ce)
        else $error("gate rise did not stop counter");

    COV_CONT_TOGGLE: cover property (
        mode_q == pit_pkg::PIT_CONT && counter_timeout);
    COV_CASC: cover property (
        mode_q == pit_pkg::PIT_SS_CASC && counter_timeout ##1 timer_output);
    COV_RSRT: cover property (status_then_counter_read && s_q.flag);
    COV_PW_STOP: cover property (
        mode_q == pit_pkg::PIT_PWID && grise && s_q.ce);

endmodule
`default_nettype wire

/* File: hdl/pit_defs.svh */
// Purpose: constants for the interval timer block
// Assumes: byte-wide register port with a three-bit register select
// Notes: register selects are the hardware register indices
`ifndef PIT_DEFS_SVH
`define PIT_DEFS_SVH

// ****************************************************************
// register selects
// ****************************************************************
`define PIT_A_CTRL 3'h1
`define PIT_A_STAT 3'h5
`define PIT_A_CNT_HI 3'h6
`define PIT_A_CNT_LO 3'h7

// ****************************************************************
// timer_control fields
// ****************************************************************
`define PIT_SOFT_RST 0
`define PIT_CLK_SEL 1
`define PIT_PRE_EN 2
`define PIT_MODE3 3
`define PIT_MODE4 4
`define PIT_MODE5 5
`define PIT_IRQ_EN 6
`define PIT_OUT_CTL 7

// ****************************************************************
// status fields, reset values and count limits
// ****************************************************************
`define PIT_STAT_FLAG 0
`define PIT_STAT_COMP 7
`define PIT_CTRL_RST 8'h01
`define PIT_LATCH_RST 16'hffff
`define PIT_PRE_LAST 3'h7
`define PIT_CNT_ZERO 16'h0000

`endif

/* File: hdl/pit_pkg.sv */
// Purpose: types shared by the interval timer block
// Assumes: nothing
// Notes: mode decode lives in the design module
package pit_pkg;

    typedef enum logic [2:0] {
        PIT_CONT,
        PIT_SS_NORM,
        PIT_SS_CASC,
        PIT_FREQ,
        PIT_PWID
    } pit_mode_t;

endpackage

/* File: tb/pit_far_end.sv */
// Purpose: far side of the timer: gate pin and external clock source
// Assumes: bench commands gate level and whether the clock runs
// Notes: pins change on the falling edge of the block clock
`timescale 1ns/1ps
`default_nettype none

module pit_far_end (
    input wire logic clock,
    input wire logic gate_cmd,
    input wire logic ext_run,
    output logic gate_input,
    output logic external_clock_input
);
    logic [1:0] div_q;

    initial begin
        gate_input = 1'b0;
        external_clock_input = 1'b0;
        div_q = 2'h0;
    end

    // halves last four cycles
    // stands low outside runs so no stray edge reaches the counter
    always @(negedge clock) begin
        gate_input <= gate_cmd;
        div_q <= ext_run ? div_q + 2'h1 : 2'h0;
        if (!ext_run) begin
            external_clock_input <= 1'b0;
        end else if (div_q == 2'h3) begin
            external_clock_input <= ~external_clock_input;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the interval timer
// Assumes: register port strobes last one cycle, driven at falling edge
// Notes: latch values kept small so each level lasts few cycles
`timescale 1ns/1ps
`default_nettype none
`include "pit_defs.svh"

module tb;
    logic clock, rst_n, bus_sel, bus_read, gate_cmd, ext_run;
    logic [2:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, v, w;
    logic irq_n, gate_input, external_clock_input, timer_output;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int len;

    pit_timer dut (.clock(clock), .rst_n(rst_n), .bus_sel(bus_sel),
        .bus_read(bus_read), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .irq_n(irq_n), .gate_input(gate_input),
        .external_clock_input(external_clock_input),
        .timer_output(timer_output));
    pit_far_end far (.clock(clock), .gate_cmd(gate_cmd),
        .ext_run(ext_run), .gate_input(gate_input),
        .external_clock_input(external_clock_input));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ****************************************
    // reporting
    // ****************************************
    task automatic close_out;
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // a hang is cut short well beyond the several hundred cycles needed
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ****************************************
    // register port and waveform helpers
    // ****************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clock);
        bus_sel = 1'b1;
        bus_read = 1'b0;
        bus_addr = a;
        bus_wdata = d;
        @(negedge clock);
        bus_sel = 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clock);
        bus_sel = 1'b1;
        bus_read = 1'b1;
        bus_addr = a;
        @(negedge clock);
        bus_sel = 1'b0;
        d = bus_rdata;
    endtask

    task automatic wl(input logic [7:0] hi, input logic [7:0] lo);
        wr(`PIT_A_CNT_HI, hi);
        wr(`PIT_A_CNT_LO, lo);
    endtask

    // length of the first whole level after the next output change
    task automatic measure(output int n);
        logic s;
        int k;
        k = 0;
        s = timer_output;
        while (timer_output === s && k < 400) begin
            @(negedge clock);
            k++;
        end
        s = timer_output;
        n = 0;
        while (timer_output === s && n < 400) begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic wait_out(input logic lvl, input int lim);
        int k;
        k = 0;
        while (timer_output !== lvl && k < lim) begin
            @(negedge clock);
            k++;
        end
        chk(timer_output, lvl);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        bus_sel = 1'b0;
        bus_read = 1'b0;
        bus_addr = 3'h0;
        bus_wdata = 8'h00;
        gate_cmd = 1'b0;
        ext_run = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        rd(`PIT_A_CTRL, v);
        chk(v, `PIT_CTRL_RST);
        rd(`PIT_A_CNT_HI, v);
        rd(`PIT_A_CNT_LO, w);
        chk({v, w}, `PIT_LATCH_RST);
        chk(irq_n, 1'b1);
        wl(8'h00, 8'h04);
        wr(`PIT_A_CTRL, 8'h82);
        measure(len);
        chk(16'(len), 16'h0005);
        wr(`PIT_A_CTRL, 8'h86);
        measure(len);
        chk(16'(len), 16'h0028);
        wr(`PIT_A_CTRL, 8'h02);
        repeat (30) @(negedge clock);
        chk(timer_output, 1'b0);
        rd(`PIT_A_CNT_LO, v);
        rd(`PIT_A_CNT_LO, w);
        chk(v != w, 1'b1);
        rd(`PIT_A_STAT, v);
        chk(v, 8'h01);
        // gate commands are non-blocking so the far end sees them a
        // whole cycle later, never racing its own falling-edge process
        gate_cmd <= 1'b1;
        repeat (8) @(negedge clock);
        rd(`PIT_A_CNT_LO, v);
        rd(`PIT_A_CNT_LO, w);
        chk(v, w);
        wr(`PIT_A_CTRL, 8'hc2);
        chk(irq_n, 1'b0);
        rd(`PIT_A_STAT, v);
        chk(v, 8'h81);
        rd(`PIT_A_CNT_HI, v);
        rd(`PIT_A_STAT, v);
        chk(v, 8'h00);
        chk(irq_n, 1'b1);
        wr(`PIT_A_CTRL, 8'h03);
        rd(`PIT_A_CNT_HI, v);
        rd(`PIT_A_CNT_LO, w);
        chk({v, w}, 16'h0004);
        chk(timer_output, 1'b0);
        wl(8'h00, 8'h10);
        wr(`PIT_A_CTRL, 8'hb2);
        gate_cmd <= 1'b0;
        repeat (6) @(negedge clock);
        chk(timer_output, 1'b1);
        wait_out(1'b0, 20);
        repeat (40) @(negedge clock);
        chk(timer_output, 1'b0);
        rd(`PIT_A_STAT, v);
        chk(v, 8'h01);
        gate_cmd <= 1'b1;
        repeat (6) @(negedge clock);
        rd(`PIT_A_CNT_LO, v);
        rd(`PIT_A_CNT_LO, w);
        chk(v != w, 1'b1);
        wr(`PIT_A_CTRL, 8'ha2);
        wait_out(1'b1, 40);
        wr(`PIT_A_CTRL, 8'h22);
        chk(timer_output, 1'b1);
        wait_out(1'b0, 40);
        gate_cmd <= 1'b0;
        ext_run <= 1'b1;
        wl(8'h00, 8'h04);
        wr(`PIT_A_CTRL, 8'h80);
        measure(len);
        chk(16'(len), 16'h0028);
        // pulse width: a 20-cycle low pulse leaves latch minus 20
        ext_run <= 1'b0;
        wr(`PIT_A_CTRL, 8'h1a);
        wl(8'h00, 8'h40);
        gate_cmd <= 1'b1;
        repeat (6) @(negedge clock);
        gate_cmd <= 1'b0;
        repeat (20) @(negedge clock);
        gate_cmd <= 1'b1;
        repeat (6) @(negedge clock);
        rd(`PIT_A_STAT, v);
        chk(v, 8'h01);
        rd(`PIT_A_CNT_HI, v);
        rd(`PIT_A_CNT_LO, w);
        chk({v, w}, 16'h002c);
        // frequency, short period: second fall before timeout flags
        wr(`PIT_A_CTRL, 8'h0a);
        wl(8'h00, 8'h40);
        gate_cmd <= 1'b0;
        repeat (4) @(negedge clock);
        gate_cmd <= 1'b1;
        repeat (6) @(negedge clock);
        gate_cmd <= 1'b0;
        repeat (4) @(negedge clock);
        rd(`PIT_A_STAT, v);
        chk(v, 8'h01);
        rd(`PIT_A_CNT_LO, v);
        rd(`PIT_A_CNT_LO, w);
        chk(v, w);
        chk(v != 8'h40, 1'b1);
        // frequency, long period: early falls restart, timeout flags
        wr(`PIT_A_CTRL, 8'h2a);
        wl(8'h00, 8'h40);
        repeat (3) begin
            gate_cmd <= 1'b1;
            repeat (5) @(negedge clock);
            gate_cmd <= 1'b0;
            repeat (5) @(negedge clock);
        end
        rd(`PIT_A_STAT, v);
        chk(v, 8'h00);
        repeat (80) @(negedge clock);
        rd(`PIT_A_STAT, v);
        chk(v, 8'h01);
        close_out();
    end
endmodule
`default_nettype wire
